// File: include/gyro_fmt_pkg.sv
package gyro_fmt_pkg;

    localparam int RATE_W       = 24;
    localparam int ANGLE_W      = 24;
    localparam int TEMP_W       = 16;
    localparam int COUNT_W      = 8;
    localparam int LAT_W        = 16;
    localparam int NUM_AXES     = 3;

    // rate lsb = 2^-14 deg/s, angle lsb = 2^-21 deg
    localparam int RATE_FRAC    = 14;
    localparam int ANGLE_FRAC   = 21;
    // internal sample period: 1000 samples/s
    localparam int SAMPLE_RATE_HZ = 1000;
    // per-sample angle = rate * 2^(21-14) / 1000
    localparam int ANGLE_SHIFT  = ANGLE_FRAC - RATE_FRAC;

    localparam int CLK_HZ       = 25000000;
    localparam int US_NS        = 1000;
    localparam int CLK_NS       = 40;
    localparam int CYC_PER_US   = US_NS / CLK_NS;

    localparam int ACC_W        = 40;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
    localparam logic [LAT_W-1:0]   LAT_MAX   = 16'hFFFF;

    typedef enum logic [1:0] {
        unit_rate,
        unit_incr_angle,
        unit_avg_rate,
        unit_integ_angle
    } unit_type;

    typedef struct packed {
        logic [RATE_W-1:0] rate;
        logic [TEMP_W-1:0] temp;
    } axis_sample_type;

    typedef struct packed {
        logic [RATE_W-1:0] value;
        logic [TEMP_W-1:0] temp;
    } axis_field_type;

endpackage

// File: src/gyro_avg_divider.sv
`timescale 1ns/1ps
`default_nettype none
// sequential signed divider: quotient = dividend / divisor, truncated toward zero
module gyro_avg_divider
    import gyro_fmt_pkg::*;
#(
    parameter int DW = 40,
    parameter int VW = 8
) (
    input  wire logic          mclk,     // clock
    input  wire logic          rst_n,    // async reset
    input  wire logic          ce,       // clock enable
    input  wire logic          start,    // begin division
    input  wire logic [DW-1:0] dividend, // signed sum
    input  wire logic [VW-1:0] divisor,  // unsigned count, nonzero
    output logic               done,     // quotient valid pulse
    output logic [DW-1:0]      quotient  // signed result
);
    logic [DW-1:0] rem_mag;
    logic [DW-1:0] quo;
    logic [VW-1:0] dv;
    logic          neg;
    logic [$clog2(DW+1)-1:0] step;
    logic          busy;
    logic [DW:0]   trial;

    always_comb begin
        trial = {rem_mag[DW-1:0], quo[DW-1]} - {{(DW+1-VW){1'b0}}, dv};
    end

    // restoring division, one bit per cycle; slow but tiny, plenty for 1 ms sampling
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rem_mag  <= '0;
            quo      <= '0;
            dv       <= '0;
            neg      <= 1'b0;
            step     <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= '0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                rem_mag <= '0;
                quo     <= dividend[DW-1] ? (~dividend + 1'b1) : dividend;
                dv      <= divisor;
                neg     <= dividend[DW-1];
                step    <= '0;
                busy    <= 1'b1;
            end else if (busy) begin
                if (!trial[DW]) begin
                    rem_mag <= trial[DW-1:0];
                    quo     <= {quo[DW-2:0], 1'b1};
                end else begin
                    rem_mag <= {rem_mag[DW-2:0], quo[DW-1]};
                    quo     <= {quo[DW-2:0], 1'b0};
                end
                step <= step + 1'b1;
                if (step == ($clog2(DW+1))'(DW - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    if (!trial[DW]) begin
                        quotient <= neg ? ~{quo[DW-2:0], 1'b1} + 1'b1 : {quo[DW-2:0], 1'b1};
                    end else begin
                        quotient <= neg ? ~{quo[DW-2:0], 1'b0} + 1'b1 : {quo[DW-2:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule // gyro_avg_divider
`default_nettype wire

// File: src/gyro_output_word_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_output_word_formatter
    import gyro_fmt_pkg::*;
#(
    parameter int AXES = NUM_AXES
) (
    input  wire logic                       mclk,        // 25 MHz clock
    input  wire logic                       rst_n,       // async reset, active low
    input  wire logic                       ce,          // clock enable
    input  wire unit_type                   out_unit,    // selected output unit
    input  wire logic                       sample_stb,  // filtered sample ready, 1 kHz
    input  wire axis_sample_type [AXES-1:0] sample_in,   // filtered rate and temperature
    input  wire logic                       tx_req,      // latch fields for a datagram
    input  wire logic                       ext_trig,    // external trigger level, synchronous
    output axis_field_type [AXES-1:0]       field_out,   // per-axis value and temperature
    output logic [COUNT_W-1:0]              count_out,   // sample counter
    output logic [LAT_W-1:0]                latency_out, // latency in microseconds
    output logic                            trig_pulse,  // falling trigger edge seen
    output logic                            field_valid  // fields updated pulse
);

    ////////////////////////////////////////////////////////////////////////////
    logic                   trig_prev;
    logic [$clog2(CYC_PER_US)-1:0] us_div;
    logic [LAT_W-1:0]       lat_count;
    logic [COUNT_W-1:0]     win_count;
    logic [COUNT_W-1:0]     free_count;
    logic                   latch;
    logic                   avg_pending;
    logic [AXES-1:0]        div_done;
    logic [ACC_W-1:0]       quot [AXES];
    logic [COUNT_W-1:0]     latched_count;

    assign latch = ce && (tx_req || (trig_pulse));

    // falling edge detect; trigger pin is a synchronous input
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev <= 1'b1;
        end else if (ce) begin
            trig_prev <= ext_trig;
        end
    end
    assign trig_pulse = trig_prev && !ext_trig;

    // microsecond timer restarted by each filtered sample; saturates at the top
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            us_div    <= '0;
            lat_count <= '0;
        end else if (ce) begin
            if (sample_stb) begin
                us_div    <= '0;
                lat_count <= '0;
            end else if (us_div == ($clog2(CYC_PER_US))'(CYC_PER_US - 1)) begin
                us_div <= '0;
                if (lat_count != LAT_MAX) begin
                    lat_count <= lat_count + 1'b1;
                end
            end else begin
                us_div <= us_div + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latency_out <= '0;
        end else if (ce && trig_pulse) begin
            latency_out <= lat_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample counters; a sample arriving with the latch closes the window it belongs to
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            win_count  <= '0;
            free_count <= '0;
        end else if (ce) begin
            if (sample_stb) begin
                free_count <= free_count + COUNT_ONE;
            end
            if (latch) begin
                win_count <= '0;
            end else if (sample_stb) begin
                win_count <= win_count + COUNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-axis accumulators and output fields
    generate
        for (genvar a = 0; a < AXES; a++) begin : g_axis
            logic [ACC_W-1:0]   sum;
            logic [ANGLE_W-1:0] incr;
            logic [ANGLE_W-1:0] integ;
            logic [ACC_W-1:0]   rate_ext;
            logic [ANGLE_W-1:0] step_angle;
            logic [ACC_W-1:0]   scaled;
            logic [ACC_W-1:0]   sum_lat;
            logic [RATE_W-1:0]  last_rate;
            logic [TEMP_W-1:0]  last_temp;

            assign rate_ext = {{(ACC_W-RATE_W){sample_in[a].rate[RATE_W-1]}}, sample_in[a].rate};
            // rate lsb 2^-14 deg/s over 1 ms gives 2^7/1000 angle lsbs per sample
            assign scaled     = (rate_ext <<< ANGLE_SHIFT);
            assign step_angle = ANGLE_W'($signed(scaled) / $signed(ACC_W'(SAMPLE_RATE_HZ)));

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    sum     <= '0;
                    incr    <= '0;
                    integ   <= '0;
                    sum_lat   <= '0;
                    last_rate <= '0;
                    last_temp <= '0;
                end else if (ce) begin
                    // keep the last sample so a latch between strobes still sees valid data
                    if (sample_stb) begin
                        integ     <= integ + step_angle;
                        last_rate <= sample_in[a].rate;
                        last_temp <= sample_in[a].temp;
                    end
                    // a sample on the latch cycle goes out now, so the next window starts empty
                    if (latch) begin
                        sum_lat <= sample_stb ? sum + rate_ext : sum;
                        sum     <= '0;
                        incr    <= '0;
                    end else if (sample_stb) begin
                        sum  <= sum + rate_ext;
                        incr <= incr + step_angle;
                    end
                end
            end

            gyro_avg_divider #(
                .DW (ACC_W),
                .VW (COUNT_W)
            ) u_div (
                .mclk     (mclk),
                .rst_n    (rst_n),
                .ce       (ce),
                .start    (avg_pending),
                .dividend (sum_lat),
                .divisor  (latched_count),
                .done     (div_done[a]),
                .quotient (quot[a])
            );

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    field_out[a] <= '0;
                end else if (ce && latch) begin
                    field_out[a].temp <= sample_stb ? sample_in[a].temp : last_temp;
                    case (out_unit)
                        unit_rate:        field_out[a].value <= sample_stb ? sample_in[a].rate : last_rate;
                        unit_incr_angle:  field_out[a].value <= sample_stb ? incr + step_angle : incr;
                        unit_integ_angle: field_out[a].value <= sample_stb ? integ + step_angle : integ;
                        unit_avg_rate:    field_out[a].value <= field_out[a].value;
                        default:          field_out[a].value <= '0;
                    endcase
                end else if (ce && div_done[a] && out_unit == unit_avg_rate) begin
                    field_out[a].value <= quot[a][RATE_W-1:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // average path: the division starts the cycle after the latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avg_pending   <= 1'b0;
            latched_count <= '0;
        end else if (ce) begin
            avg_pending <= latch && out_unit == unit_avg_rate && (win_count != '0 || sample_stb);
            if (latch) begin
                latched_count <= win_count + (sample_stb ? COUNT_ONE : '0);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_out   <= '0;
            field_valid <= 1'b0;
        end else if (ce) begin
            field_valid <= latch && out_unit != unit_avg_rate || (div_done[0] && out_unit == unit_avg_rate);
            if (latch) begin
                if (out_unit == unit_incr_angle || out_unit == unit_avg_rate) begin
                    count_out <= win_count + (sample_stb ? COUNT_ONE : '0);
                end else begin
                    count_out <= free_count + (sample_stb ? COUNT_ONE : '0);
                end
            end
        end
    end

endmodule // gyro_output_word_formatter
`default_nettype wire

// File: verif/gyro_fmt_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_fmt_sva
    import gyro_fmt_pkg::*;
#(
    parameter int AXES = NUM_AXES
) (
    input wire logic                       mclk,        // clock
    input wire logic                       rst_n,       // async reset
    input wire logic                       ce,          // clock enable
    input wire unit_type                   out_unit,    // output unit
    input wire logic                       sample_stb,  // sample strobe
    input wire axis_sample_type [AXES-1:0] sample_in,   // samples
    input wire logic                       tx_req,      // latch request
    input wire logic                       ext_trig,    // trigger level
    input wire axis_field_type [AXES-1:0]  field_out,   // fields
    input wire logic [COUNT_W-1:0]         count_out,   // counter
    input wire logic [LAT_W-1:0]           latency_out, // latency
    input wire logic                       trig_pulse,  // trigger edge
    input wire logic                       field_valid  // fields updated
);
    wire  take = ce && (tx_req || trig_pulse);
    wire  smp  = ce && sample_stb;
    logic [COUNT_W-1:0] win, win_lat, tot, tot_lat;
    logic [TEMP_W-1:0]  t_lat;
    logic [RATE_W-1:0]  r_lat;
    // shadow the window and free counts so a latch can be judged against them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            win <= '0; win_lat <= '0; tot <= '0; tot_lat <= '0; t_lat <= '0; r_lat <= '0;
        end else begin
            tot <= tot + COUNT_W'(smp);
            win <= take ? '0 : win + COUNT_W'(smp);
            if (take) begin
                win_lat <= win + COUNT_W'(smp);
                tot_lat <= tot + COUNT_W'(smp);
                if (smp) begin
                    t_lat <= sample_in[0].temp;
                    r_lat <= sample_in[1].rate;
                end
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    valid_after_latch_a: assert property (take && out_unit != unit_avg_rate |=> field_valid)
        else $error("no field update after latch");
    valid_cause_a: assert property (field_valid && out_unit != unit_avg_rate |-> $past(take))
        else $error("field update without latch");
    trig_edge_a: assert property (trig_pulse |-> !ext_trig && $past(ext_trig))
        else $error("trigger pulse without falling edge");
    trig_seen_a: assert property (ce && $fell(ext_trig) |-> trig_pulse)
        else $error("falling trigger edge missed");
    out_hold_a: assert property (!$past(take) |-> $stable(count_out) && $stable(latency_out))
        else $error("outputs moved between latches");
    window_count_a: assert property (field_valid && out_unit inside {unit_incr_angle, unit_avg_rate}
        |-> count_out == win_lat) else $error("window count wrong");
    free_count_a: assert property (field_valid && out_unit inside {unit_rate, unit_integ_angle}
        |-> count_out == tot_lat) else $error("free count wrong");
    axis_temp_a: assert property (field_valid && $past(smp && take) |-> field_out[0].temp == t_lat)
        else $error("axis temperature wrong");
    rate_field_a: assert property (field_valid && out_unit == unit_rate && $past(smp && take)
        |-> field_out[1].value == r_lat) else $error("rate field wrong");
    cover property (field_valid && out_unit == unit_incr_angle);
    cover property (field_valid && out_unit == unit_integ_angle);
    cover property (trig_pulse);
    cover property (take && smp);
endmodule // gyro_fmt_sva
bind gyro_output_word_formatter gyro_fmt_sva #(.AXES(AXES)) u_gyro_fmt_sva (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .out_unit(out_unit), .sample_stb(sample_stb),
    .sample_in(sample_in), .tx_req(tx_req), .ext_trig(ext_trig), .field_out(field_out),
    .count_out(count_out), .latency_out(latency_out), .trig_pulse(trig_pulse),
    .field_valid(field_valid));
`default_nettype wire

// File: verif/gyro_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_host_model (
    input  wire logic mclk,     // clock
    input  wire logic trig_go,  // ask for one trigger
    output var logic  ext_trig  // trigger line, pulled up when idle
);
    initial ext_trig = 1'b1;
    // the line is open collector, so idle is the pull-up level
    always @(posedge mclk) begin
        if (trig_go) begin
            @(negedge mclk) ext_trig <= 1'b0;
            repeat (3) @(negedge mclk);
            ext_trig <= 1'b1;
        end
    end
endmodule // gyro_host_model
`default_nettype wire

// File: verif/gyro_output_word_formatter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_output_word_formatter_bench;
    import gyro_fmt_pkg::*;
    typedef struct {
        unit_type u; logic [2:0][23:0] v; logic [2:0][15:0] t; logic [7:0] c; int lat;
    } note_type;
    logic mclk = 0, rst_n = 0, ce = 1, sample_stb = 0, tx_req = 0, trig_go = 0;
    logic ext_trig, trig_pulse, field_valid;
    unit_type              out_unit = unit_rate;
    axis_sample_type [2:0] sample_in = '0;
    axis_field_type [2:0]  field_out;
    logic [7:0]            count_out;
    logic [15:0]           latency_out;
    logic [2:0][23:0]      last_r = '0, incr = '0, integ = '0;
    logic [2:0][15:0]      tmp = '0;
    longint                sum[3] = '{0, 0, 0};
    int n_mismatch = 0, cmp_count = 0, win = 0, tot = 0, seed = 32'habe747fc;
    time stime = 0;
    note_type q[$];

    gyro_output_word_formatter #(.AXES(3)) u_gyro_output_word_formatter (.mclk(mclk), .rst_n(rst_n),
        .ce(ce), .out_unit(out_unit), .sample_stb(sample_stb), .sample_in(sample_in), .tx_req(tx_req),
        .ext_trig(ext_trig), .field_out(field_out), .count_out(count_out), .latency_out(latency_out),
        .trig_pulse(trig_pulse), .field_valid(field_valid));
    gyro_host_model u_gyro_host_model (.mclk(mclk), .trig_go(trig_go), .ext_trig(ext_trig));

    always #20 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // expected fields of the latch being issued; window restarts after it
    task automatic note(input int lat);
        note_type n;
        n.u = out_unit; n.t = tmp; n.lat = lat;
        n.c = (out_unit inside {unit_incr_angle, unit_avg_rate}) ? 8'(win) : 8'(tot);
        for (int a = 0; a < 3; a++) begin
            case (out_unit)
                unit_rate:       n.v[a] = last_r[a];
                unit_incr_angle: n.v[a] = incr[a];
                unit_avg_rate:   n.v[a] = 24'(sum[a] / win);
                default:         n.v[a] = integ[a];
            endcase
        end
        q.push_back(n);
        incr = '0; sum = '{0, 0, 0}; win = 0;
    endtask
    // samples are exact multiples of 1000 lsb so the angle per sample has no rounding
    task automatic smp(input int n, input bit req);
        int k;
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            // first and latching samples are never dropped, so no averaging window is empty
            tx_req = req && i == n - 1;
            ce = i == 0 || tx_req || ($random(seed) & 7) != 0;
            sample_stb = 1'b1;
            for (int a = 0; a < 3; a++) begin
                k = $random(seed) % 4000;
                sample_in[a].rate = 24'(k * 1000);
                sample_in[a].temp = 16'($random(seed));
                if (ce) begin
                    last_r[a] = 24'(k * 1000); tmp[a] = sample_in[a].temp;
                    incr[a] += 24'(k * 128); integ[a] += 24'(k * 128); sum[a] += k * 1000;
                end
            end
            if (ce) begin
                win++; tot++; stime = $time;
            end
            if (tx_req) note(-1);
            @(negedge mclk);
            sample_stb = 1'b0; tx_req = 1'b0; ce = 1'b1;
        end
    endtask
    task automatic req(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            note(-1); tx_req = 1'b1;
        end
        @(negedge mclk) tx_req = 1'b0;
        repeat (out_unit == unit_avg_rate ? 60 : 2) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // outputs are looked at mid-cycle, away from the edge that launches them
    always @(negedge mclk) begin
        note_type n;
        if (field_valid === 1'b1) begin
            if (q.size() == 0) chk(1'b0, "field update without latch");
            else begin
                n = q.pop_front();
                for (int a = 0; a < 3; a++) begin
                    chk(field_out[a].value === n.v[a], "axis value");
                    chk(field_out[a].temp === n.t[a], "axis temperature");
                end
                chk(count_out === n.c, "counter");
                if (n.lat >= 0) chk(16'(latency_out - 16'(n.lat - 1)) <= 16'h0002, "latency");
            end
        end
    end
    initial begin
        repeat (100000) @(posedge mclk);
        chk(1'b0, "timeout");
        conclude();
    end
    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        for (int u = 0; u < 4; u++) begin
            @(negedge mclk) out_unit = unit_type'(u);
            smp(1 + ($random(seed) & 3), 1'b0);
            req(1);
            smp(3, 1'b1);
            if (u != 2) req(2);
            smp(2, 1'b0);
            repeat (85) @(negedge mclk);
            note(int'(($time + 40 - stime) / 1000)); trig_go = 1'b1;
            @(negedge mclk) trig_go = 1'b0;
            repeat (60) @(negedge mclk);
        end
        out_unit = unit_rate;
        smp(260, 1'b0);
        req(1);
        for (int i = 0; i < 200 && q.size() != 0; i++) @(negedge mclk);
        if (q.size() != 0) chk(1'b0, "missing field updates");
        conclude();
    end
endmodule // gyro_output_word_formatter_bench
`default_nettype wire
